//--- core/rtc_event_alarm_core.v
// Purpose: Calendar, alarms, event detect, supply flags and stamps.
// Assumes: Supply comparators and switchover sit outside as pins.
// Notes: Host access is by plain strobes; no serial engine here.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_alarm_defs.vh"
module rtc_event_alarm_core #(
   parameter PULSE_CYCLES = `RTC_PULSE_MS * (`RTC_CORE_HZ / 1000)
) (
   input wire i_core_clk,
   input wire i_nrst,
   input wire i_xtal,
   input wire i_ac_line,
   input wire i_ac_qualified,
   input wire i_ac_60hz,
   input wire i_event_input,
   input wire i_on_backup,
   input wire i_supply_below_trip,
   input wire i_backup_below_85,
   input wire i_backup_below_75,
   input wire i_event_enable,
   input wire i_event_on_battery_ctl,
   input wire i_event_clear,
   input wire i_host_if_on_battery,
   input wire [2:0] i_freq_select,
   input wire i_freq_out_on_battery_n,
   input wire i_hour_12,
   input wire i_irq_pulse_mode,
   input wire i_auto_clear_on_read,
   input wire [`AL_W-1:0] i_alarm0_cfg,
   input wire [`AL_W-1:0] i_alarm1_cfg,
   input wire i_alarm0_clear,
   input wire i_alarm1_clear,
   input wire i_status_read,
   input wire i_time_wr,
   input wire [3:0] i_wr_tenths,
   input wire [5:0] i_wr_sec,
   input wire [5:0] i_wr_min,
   input wire [4:0] i_wr_hour,
   input wire [2:0] i_wr_weekday,
   input wire [4:0] i_wr_date,
   input wire [3:0] i_wr_month,
   input wire [6:0] i_wr_year,
   input wire i_pd_stamp_zero,
   input wire i_clear_stamp_ctl,
   input wire i_pu_stamp_zero,
   output reg [3:0] o_tenths,
   output reg [5:0] o_sec,
   output reg [5:0] o_min,
   output reg [4:0] o_hour,
   output reg o_pm,
   output reg [2:0] o_weekday,
   output reg [4:0] o_date,
   output reg [3:0] o_month,
   output reg [6:0] o_year,
   output reg [7:0] o_main_status_reg,
   output reg o_event_flag,
   output wire o_event_indicator_n_o,
   output wire o_event_indicator_n_oe,
   output wire o_irq_n_o,
   output wire o_irq_n_oe,
   output wire o_freq_out,
   output reg o_host_if_active,
   output reg [`ST_W-1:0] o_power_down_stamp,
   output reg o_power_down_stamp_full,
   output reg [`ST_W-1:0] o_power_up_stamp
);
   // ==========================================
   // Reset and pin synchronisers
   reg [1:0] rst_sync_reg;
   wire rst_n = rst_sync_reg[1];
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   wire [7:0] pin_raw = {i_xtal, i_ac_line, i_ac_qualified, i_event_input,
      i_on_backup, i_supply_below_trip, i_backup_below_85,
      i_backup_below_75};
   reg [7:0] pin_meta_reg;
   reg [7:0] pin_reg;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_sync
         always @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_meta_reg[g] <= 1'b0;
               pin_reg[g] <= 1'b0;
            end else begin
               pin_meta_reg[g] <= pin_raw[g];
               pin_reg[g] <= pin_meta_reg[g];
            end
         end
      end
   endgenerate
   wire xtal = pin_reg[7];
   wire ac = pin_reg[6];
   wire ac_ok = pin_reg[5];
   wire ev_in = pin_reg[4];
   wire backup = pin_reg[3];
   reg xtal_prev_reg, ac_prev_reg, backup_prev_reg;
   wire xtal_rise = xtal && !xtal_prev_reg;
   wire ac_rise = ac && !ac_prev_reg;
   // Host strobes are dropped while the host interface sleeps.
   wire host_ok = !backup || i_host_if_on_battery;
   // ==========================================
   // Timebase
   // The crystal path accumulates ten per edge, so tenths are exact.
   reg [15:0] xacc_reg;
   reg [14:0] xdiv_reg;
   reg [2:0] ac_cnt_reg;
   reg sq5_reg, sq1_reg;
   wire [16:0] xacc_sum = {1'b0, xacc_reg} + 17'h0000a;
   wire [2:0] ac_limit = i_ac_60hz ? `RTC_AC60_PER_TICK : `RTC_AC50_PER_TICK;
   wire tick = ac_ok ? (ac_rise && ac_cnt_reg == ac_limit - 3'h1) :
      (xtal_rise && xacc_sum >= `RTC_XTAL_HZ);
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_prev_reg <= 1'b0;
         ac_prev_reg <= 1'b0;
         backup_prev_reg <= 1'b0;
         xacc_reg <= 16'h0000;
         xdiv_reg <= 15'h0000;
         ac_cnt_reg <= 3'h0;
      end else begin
         xtal_prev_reg <= xtal;
         ac_prev_reg <= ac;
         backup_prev_reg <= backup;
         if (xtal_rise) begin
            xdiv_reg <= xdiv_reg + 15'h0001;
            xacc_reg <= (xacc_sum >= `RTC_XTAL_HZ) ?
               xacc_sum[15:0] - 16'h8000 : xacc_sum[15:0];
         end
         if (ac_rise) begin
            ac_cnt_reg <= (ac_cnt_reg == ac_limit - 3'h1) ? 3'h0 :
               ac_cnt_reg + 3'h1;
         end
      end
   end
   // ==========================================
   // Calendar
   reg [3:0] tenths_reg;
   reg [5:0] sec_reg, min_reg;
   reg [4:0] hour_reg, date_reg;
   reg [2:0] wday_reg;
   reg [3:0] month_reg;
   reg [6:0] year_reg;
   reg frozen_reg;
   reg [4:0] dim;
   // Years are taken within one century, where every fourth is a leap.
   always @* begin
      case (month_reg)
         4'h2: dim = (year_reg[1:0] == 2'h0) ? 5'h1d : 5'h1c;
         4'h4, 4'h6, 4'h9, 4'hb: dim = 5'h1e;
         default: dim = 5'h1f;
      endcase
   end
   wire wr_ok = i_time_wr && host_ok;
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tenths_reg <= 4'h0;
         sec_reg <= 6'h00;
         min_reg <= 6'h00;
         hour_reg <= 5'h00;
         wday_reg <= 3'h0;
         date_reg <= `DATE_RESET;
         month_reg <= `MONTH_RESET;
         year_reg <= 7'h00;
         frozen_reg <= 1'b1;
         sq5_reg <= 1'b0;
         sq1_reg <= 1'b0;
      end else if (wr_ok) begin
         tenths_reg <= i_wr_tenths;
         sec_reg <= i_wr_sec;
         min_reg <= i_wr_min;
         hour_reg <= i_wr_hour;
         wday_reg <= i_wr_weekday;
         date_reg <= i_wr_date;
         month_reg <= i_wr_month;
         year_reg <= i_wr_year;
         frozen_reg <= 1'b0;
      end else if (tick && !frozen_reg) begin
         sq5_reg <= !sq5_reg;
         if (tenths_reg == 4'h4 || tenths_reg == 4'h9) begin
            sq1_reg <= !sq1_reg;
         end
         if (tenths_reg != 4'h9) begin
            tenths_reg <= tenths_reg + 4'h1;
         end else begin
            tenths_reg <= 4'h0;
            if (sec_reg != 6'h3b) begin
               sec_reg <= sec_reg + 6'h01;
            end else begin
               sec_reg <= 6'h00;
               if (min_reg != 6'h3b) begin
                  min_reg <= min_reg + 6'h01;
               end else begin
                  min_reg <= 6'h00;
                  if (hour_reg != 5'h17) begin
                     hour_reg <= hour_reg + 5'h01;
                  end else begin
                     hour_reg <= 5'h00;
                     wday_reg <= (wday_reg == 3'h6) ? 3'h0 : wday_reg + 3'h1;
                     if (date_reg < dim) begin
                        date_reg <= date_reg + 5'h01;
                     end else begin
                        date_reg <= 5'h01;
                        if (month_reg != 4'hc) begin
                           month_reg <= month_reg + 4'h1;
                        end else begin
                           month_reg <= 4'h1;
                           year_reg <= (year_reg == 7'h63) ? 7'h00 :
                              year_reg + 7'h01;
                        end
                     end
                  end
               end
            end
         end
      end
   end
   // ==========================================
   // Alarms
   wire match0, match1;
   wire alarm_on = !backup;
   rtc_alarm_match u_alarm0 (
      .i_clk(i_core_clk), .i_rst_n(rst_n), .i_enable(alarm_on),
      .i_cfg(i_alarm0_cfg), .i_sec(sec_reg), .i_min(min_reg),
      .i_hour(hour_reg), .i_date(date_reg), .i_month(month_reg),
      .i_weekday(wday_reg), .i_year(year_reg), .o_match(match0)
   );
   rtc_alarm_match u_alarm1 (
      .i_clk(i_core_clk), .i_rst_n(rst_n), .i_enable(alarm_on),
      .i_cfg(i_alarm1_cfg), .i_sec(sec_reg), .i_min(min_reg),
      .i_hour(hour_reg), .i_date(date_reg), .i_month(month_reg),
      .i_weekday(wday_reg), .i_year(year_reg), .o_match(match1)
   );
   reg alarm0_flag, alarm1_flag, clock_fail_flag;
   reg [22:0] pulse_cnt_reg;
   wire rd_clear = i_status_read && i_auto_clear_on_read && host_ok;
   // A match in the cycle of a clear keeps the flag set.
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm0_flag <= 1'b0;
         alarm1_flag <= 1'b0;
         clock_fail_flag <= 1'b1;
         pulse_cnt_reg <= 23'h000000;
      end else begin
         if (match0) begin
            alarm0_flag <= 1'b1;
         end else if ((i_alarm0_clear && host_ok) || rd_clear) begin
            alarm0_flag <= 1'b0;
         end
         if (match1) begin
            alarm1_flag <= 1'b1;
         end else if ((i_alarm1_clear && host_ok) || rd_clear) begin
            alarm1_flag <= 1'b0;
         end
         if (wr_ok) begin
            clock_fail_flag <= 1'b0;
         end
         // Idle in single-event mode, so a mode switch shows no stale pulse.
         if (backup || !i_irq_pulse_mode) begin
            pulse_cnt_reg <= 23'h000000;
         end else if (match0 || match1) begin
            pulse_cnt_reg <= PULSE_CYCLES[22:0];
         end else if (pulse_cnt_reg != 23'h000000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 23'h000001;
         end
      end
   end
   wire irq_on = !backup && (i_irq_pulse_mode ?
      (pulse_cnt_reg != 23'h000000) :
      (alarm0_flag || alarm1_flag));
   assign o_irq_n_o = 1'b0;
   assign o_irq_n_oe = irq_on;
   // ==========================================
   // Event detect
   wire ev_live = ev_in && i_event_enable &&
      (!backup || i_event_on_battery_ctl);
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_event_flag <= 1'b0;
      end else if (ev_live) begin
         o_event_flag <= 1'b1;
      end else if (i_event_clear && host_ok) begin
         o_event_flag <= 1'b0;
      end
   end
   assign o_event_indicator_n_o = 1'b0;
   assign o_event_indicator_n_oe = o_event_flag;
   // ==========================================
   // Switchover stamps
   wire to_backup = backup && !backup_prev_reg;
   wire to_main = !backup && backup_prev_reg;
   wire [`ST_W-1:0] now_stamp = {year_reg, month_reg, date_reg, hour_reg,
      min_reg};
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_power_down_stamp <= {`ST_W{1'b0}};
         o_power_down_stamp_full <= 1'b0;
         o_power_up_stamp <= {`ST_W{1'b0}};
      end else begin
         if (to_backup && !o_power_down_stamp_full) begin
            o_power_down_stamp <= now_stamp;
            o_power_down_stamp_full <= 1'b1;
         end else if (host_ok && (i_pd_stamp_zero || i_clear_stamp_ctl)) begin
            o_power_down_stamp <= {`ST_W{1'b0}};
            o_power_down_stamp_full <= 1'b0;
         end
         if (to_main) begin
            o_power_up_stamp <= now_stamp;
         end else if (host_ok && i_pu_stamp_zero) begin
            o_power_up_stamp <= {`ST_W{1'b0}};
         end
      end
   end
   // ==========================================
   // Outputs and status
   // Hours count 0 to 23 inside; 12-hour form is only a view of them.
   wire pm = hour_reg >= 5'h0c;
   wire [4:0] h12 = pm ? hour_reg - 5'h0c : hour_reg;
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_tenths <= 4'h0;
         o_sec <= 6'h00;
         o_min <= 6'h00;
         o_hour <= 5'h00;
         o_pm <= 1'b0;
         o_weekday <= 3'h0;
         o_date <= `DATE_RESET;
         o_month <= `MONTH_RESET;
         o_year <= 7'h00;
         o_main_status_reg <= `SR_RESET;
         o_host_if_active <= 1'b0;
      end else begin
         o_tenths <= tenths_reg;
         o_sec <= sec_reg;
         o_min <= min_reg;
         o_hour <= !i_hour_12 ? hour_reg :
            (h12 == 5'h00 ? 5'h0c : h12);
         o_pm <= i_hour_12 && pm;
         o_weekday <= wday_reg;
         o_date <= date_reg;
         o_month <= month_reg;
         o_year <= year_reg;
         o_main_status_reg <= 8'h00;
         o_main_status_reg[`SR_BACKUP] <= backup;
         o_main_status_reg[`SR_ALARM1_FLAG] <= alarm1_flag;
         o_main_status_reg[`SR_ALARM0_FLAG] <= alarm0_flag;
         o_main_status_reg[`SR_LOW_SUPPLY_FLAG] <= pin_reg[2];
         o_main_status_reg[`SR_LB85] <= pin_reg[1] | pin_reg[0];
         o_main_status_reg[`SR_LB75] <= pin_reg[0];
         o_main_status_reg[`SR_CFAIL] <= clock_fail_flag;
         o_host_if_active <= host_ok;
      end
   end
   // ==========================================
   // Frequency output
   rtc_freq_out u_freq (
      .i_clk(i_core_clk), .i_rst_n(rst_n), .i_select(i_freq_select),
      .i_allow(!backup || !i_freq_out_on_battery_n), .i_ac_ok(ac_ok),
      .i_xtal(xtal), .i_xdiv(xdiv_reg), .i_ac(ac), .i_sq5(sq5_reg),
      .i_sq1(sq1_reg), .o_freq_out(o_freq_out)
   );
endmodule // rtc_event_alarm_core
`default_nettype wire

//--- core/rtc_event_alarm_defs.vh
// Purpose: Shared constants of the event and alarm clock core.
// Assumes: A 25 MHz core clock; calendar fields are plain binary.
// Notes: Field positions describe the packed alarm and stamp vectors.
`ifndef RTC_EVENT_ALARM_DEFS_VH
`define RTC_EVENT_ALARM_DEFS_VH
// ==========================================
// Timing
`define RTC_CORE_HZ 25000000
`define RTC_PULSE_MS 250
`define RTC_XTAL_HZ 32768
`define RTC_TICKS_PER_SEC 10
`define RTC_AC50_PER_TICK 3'h5
`define RTC_AC60_PER_TICK 3'h6
// ==========================================
// Alarm vector: value in low bits, enable in top bit of each field
`define AL_SEC_LO 0
`define AL_SEC_EN 6
`define AL_MIN_LO 7
`define AL_MIN_EN 13
`define AL_HR_LO 14
`define AL_HR_EN 19
`define AL_DT_LO 20
`define AL_DT_EN 25
`define AL_MO_LO 26
`define AL_MO_EN 30
`define AL_DW_LO 31
`define AL_DW_EN 34
`define AL_YR_LO 35
`define AL_YR_EN 42
`define AL_W 43
// ==========================================
// Stamp vector: minute, hour, date, month, year
`define ST_MIN_LO 0
`define ST_HR_LO 6
`define ST_DT_LO 11
`define ST_MO_LO 16
`define ST_YR_LO 20
`define ST_W 27
// ==========================================
// Frequency select codes
`define FS_OFF 3'h0
`define FS_32K 3'h1
`define FS_4K 3'h2
`define FS_1K 3'h3
`define FS_64 3'h4
`define FS_LINE 3'h5
`define FS_5HZ 3'h6
`define FS_1HZ 3'h7
// ==========================================
// Status byte bit positions and reset values
`define SR_BACKUP 7
`define SR_ALARM1_FLAG 5
`define SR_ALARM0_FLAG 4
`define SR_LOW_SUPPLY_FLAG 3
`define SR_LB85 2
`define SR_LB75 1
`define SR_CFAIL 0
`define SR_RESET 8'h01
`define DATE_RESET 5'h01
`define MONTH_RESET 4'h1
`endif

//--- core/rtc_alarm_match.v
// Purpose: Compares one alarm setting against the running calendar.
// Assumes: Calendar fields come from flip-flops on the same clock.
// Notes: Emits one pulse when the comparison first becomes true.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_alarm_defs.vh"
module rtc_alarm_match (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_enable,
   input wire [`AL_W-1:0] i_cfg,
   input wire [5:0] i_sec,
   input wire [5:0] i_min,
   input wire [4:0] i_hour,
   input wire [4:0] i_date,
   input wire [3:0] i_month,
   input wire [2:0] i_weekday,
   input wire [6:0] i_year,
   output reg o_match
);
   // ==========================================
   // Field compare
   // A cleared enable makes its field a don't-care.
   wire sec_ok = !i_cfg[`AL_SEC_EN] ||
      i_cfg[`AL_SEC_LO +: 6] == i_sec;
   wire min_ok = !i_cfg[`AL_MIN_EN] ||
      i_cfg[`AL_MIN_LO +: 6] == i_min;
   wire hr_ok = !i_cfg[`AL_HR_EN] ||
      i_cfg[`AL_HR_LO +: 5] == i_hour;
   wire dt_ok = !i_cfg[`AL_DT_EN] ||
      i_cfg[`AL_DT_LO +: 5] == i_date;
   wire mo_ok = !i_cfg[`AL_MO_EN] ||
      i_cfg[`AL_MO_LO +: 4] == i_month;
   wire dw_ok = !i_cfg[`AL_DW_EN] ||
      i_cfg[`AL_DW_LO +: 3] == i_weekday;
   wire yr_ok = !i_cfg[`AL_YR_EN] ||
      i_cfg[`AL_YR_LO +: 7] == i_year;
   wire hit = sec_ok && min_ok && hr_ok && dt_ok && mo_ok && dw_ok &&
      yr_ok;
   reg hit_reg;
   // ==========================================
   // Edge of the match
   // An alarm with no field enabled would match forever, so it is held off.
   wire any_en = i_cfg[`AL_SEC_EN] | i_cfg[`AL_MIN_EN] | i_cfg[`AL_HR_EN] |
      i_cfg[`AL_DT_EN] | i_cfg[`AL_MO_EN] | i_cfg[`AL_DW_EN] |
      i_cfg[`AL_YR_EN];
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hit_reg <= 1'b0;
         o_match <= 1'b0;
      end else begin
         hit_reg <= hit && any_en && i_enable;
         o_match <= hit && any_en && i_enable && !hit_reg;
      end
   end
endmodule // rtc_alarm_match
`default_nettype wire

//--- core/rtc_freq_out.v
// Purpose: Selects the square wave driven on the frequency output.
// Assumes: Sources are flip-flop levels on the core clock.
// Notes: Output is low when switched off.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_alarm_defs.vh"
module rtc_freq_out (
   input wire i_clk,
   input wire i_rst_n,
   input wire [2:0] i_select,
   input wire i_allow,
   input wire i_ac_ok,
   input wire i_xtal,
   input wire [14:0] i_xdiv,
   input wire i_ac,
   input wire i_sq5,
   input wire i_sq1,
   output reg o_freq_out
);
   reg wave;
   // ==========================================
   // Source selection
   // Slow rates follow the line clock only while it is qualified.
   always @* begin
      case (i_select)
         `FS_32K: wave = i_xtal;
         `FS_4K: wave = i_xdiv[2];
         `FS_1K: wave = i_xdiv[4];
         `FS_64: wave = i_xdiv[8];
         `FS_LINE: wave = i_ac_ok ? i_ac : i_xdiv[8];
         `FS_5HZ: wave = i_sq5;
         `FS_1HZ: wave = i_sq1;
         default: wave = 1'b0;
      endcase
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_freq_out <= 1'b0;
      end else begin
         o_freq_out <= wave & i_allow;
      end
   end
endmodule // rtc_freq_out
`default_nettype wire

//--- testbench/rtc_core_checker.sv
// Purpose: Port checks for the event and alarm clock core.
// Assumes: One clock domain; i_nrst is low active.
// Notes: PULSE_CYCLES is handed on from the bound instance.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker
module rtc_core_checker #(parameter PULSE_CYCLES = 20) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_event_enable,
   input wire logic i_event_clear,
   input wire logic i_on_backup,
   input wire logic i_host_if_on_battery,
   input wire logic i_supply_below_trip,
   input wire logic i_backup_below_85,
   input wire logic i_backup_below_75,
   input wire logic i_irq_pulse_mode,
   input wire logic i_pd_stamp_zero,
   input wire logic i_clear_stamp_ctl,
   input wire logic [7:0] o_main_status_reg,
   input wire logic o_event_flag,
   input wire logic o_event_indicator_n_oe,
   input wire logic o_irq_n_o,
   input wire logic o_irq_n_oe,
   input wire logic o_host_if_active,
   input wire logic [26:0] o_power_down_stamp,
   input wire logic o_power_down_stamp_full
);
   logic [31:0] run_reg;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // Counts the present low stretch; a stuck pulse shows as an overrun.
   always @(posedge i_core_clk or negedge i_nrst)
      if (!i_nrst) run_reg <= 32'h0;
      else run_reg <= o_irq_n_oe ? run_reg + 32'h1 : 32'h0;
   a_evt_pin_tie: assert property (
      o_event_indicator_n_oe == o_event_flag && !o_irq_n_o)
      else $error("event pin or interrupt drive wrong");
   a_evt_needs_en: assert property ($rose(o_event_flag) |->
      $past(i_event_enable) || $past(i_event_enable, 2)
      || $past(i_event_enable, 3)) else $error("event while disabled");
   a_evt_flag_hold: assert property (o_event_flag && !i_event_clear
      && !$past(i_event_clear) |=> o_event_flag)
      else $error("event flag dropped without clear");
   a_host_gated: assert property (
      (i_on_backup && !i_host_if_on_battery)[*5] |-> !o_host_if_active)
      else $error("host port live on backup");
   a_supply_flags: assert property ($stable({i_supply_below_trip,
      i_backup_below_85, i_backup_below_75})[*6] |->
      o_main_status_reg[3:1] == {i_supply_below_trip,
      i_backup_below_85 | i_backup_below_75, i_backup_below_75})
      else $error("supply flags wrong");
   a_no_alarm_bak: assert property (i_on_backup[*8] |->
      !$rose(o_main_status_reg[4]) && !$rose(o_main_status_reg[5]))
      else $error("alarm raised on backup");
   a_irq_single: assert property (
      !i_irq_pulse_mode && $rose(o_irq_n_oe) |=> o_main_status_reg[5:4] != 2'h0)
      else $error("interrupt without alarm flag");
   a_irq_pulse_len: assert property ($fell(o_irq_n_oe)
      && i_irq_pulse_mode && !i_on_backup |-> run_reg == PULSE_CYCLES)
      else $error("pulse length wrong");
   a_pd_stamp_keep: assert property (o_power_down_stamp_full
      && !i_pd_stamp_zero && !i_clear_stamp_ctl && !$past(i_pd_stamp_zero)
      && !$past(i_clear_stamp_ctl) |=> $stable(o_power_down_stamp))
      else $error("held stamp overwritten");
endmodule // rtc_core_checker
bind rtc_event_alarm_core rtc_core_checker #(.PULSE_CYCLES(PULSE_CYCLES))
   u_chk (.i_core_clk, .i_nrst, .i_event_enable, .i_event_clear,
   .i_on_backup, .i_host_if_on_battery, .i_supply_below_trip,
   .i_backup_below_85, .i_backup_below_75, .i_irq_pulse_mode,
   .i_pd_stamp_zero, .i_clear_stamp_ctl, .o_main_status_reg,
   .o_event_flag, .o_event_indicator_n_oe, .o_irq_n_o, .o_irq_n_oe,
   .o_host_if_active, .o_power_down_stamp, .o_power_down_stamp_full);
`default_nettype wire

//--- testbench/host_model.sv
// Purpose: Host side that issues one-cycle service strobes.
// Assumes: Requests are raised for a single clock.
// Notes: Zero writes to flags and stamps are modelled as strobes.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host model
module host_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [2:0] i_op,
   output logic [6:0] o_strobe
);
   // Bit order: event clear, alarm0, alarm1, status read, stamp zero,
   // stamp clear control, power-up stamp zero.
   always @(posedge i_clk)
      o_strobe <= i_go ? 7'h01 << i_op : 7'h00;
endmodule // host_model
`default_nettype wire

//--- testbench/test_rtc_event_alarm_core.sv
// Purpose: Self-checking run of the event and alarm clock core.
// Assumes: Qualified 50 Hz line clock speeds up the calendar.
// Notes: Pulse length shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
module test_rtc_event_alarm_core;
   logic clk = 0, nrst = 0, ac = 0, xt = 0, ev = 0, bak = 0, trip = 0;
   logic b85 = 0, b75 = 0, een = 0, eob = 0, hob = 0, pm = 0, acr = 0;
   logic twr = 0, go = 0, fon = 0;
   logic [2:0] op = 0, fsel = 0, wd = 0, r;
   logic [42:0] al0 = 0, al1 = 0;
   logic [5:0] mn = 0, sec = 6'h3a;
   logic [4:0] hr = 0, dt = 1;
   logic [3:0] mo = 1;
   logic [6:0] yr = 0;
   wire [6:0] s;
   wire [26:0] pds, pus;
   wire [7:0] st;
   wire [5:0] osec, omin;
   wire [6:0] oy;
   wire [4:0] oh, odt;
   wire [3:0] omo;
   wire [2:0] owd;
   wire pdf, fo, hact, ef, eoe, ioe;
   integer miscompares = 0, n_tests = 0, k;
   always #20 clk = ~clk;
   always #80 ac = ~ac;
   always #15259 xt = ~xt;
   host_model host (.i_clk(clk), .i_go(go), .i_op(op), .o_strobe(s));
   rtc_event_alarm_core #(.PULSE_CYCLES(20)) dut (.i_core_clk(clk),
      .i_nrst(nrst), .i_xtal(xt), .i_ac_line(ac), .i_ac_qualified(1'b1),
      .i_ac_60hz(1'b0), .i_event_input(ev), .i_on_backup(bak),
      .i_supply_below_trip(trip), .i_backup_below_85(b85),
      .i_backup_below_75(b75), .i_event_enable(een),
      .i_event_on_battery_ctl(eob), .i_event_clear(s[0]),
      .i_host_if_on_battery(hob), .i_freq_select(fsel),
      .i_freq_out_on_battery_n(fon), .i_hour_12(1'b0),
      .i_irq_pulse_mode(pm), .i_auto_clear_on_read(acr),
      .i_alarm0_cfg(al0), .i_alarm1_cfg(al1), .i_alarm0_clear(s[1]),
      .i_alarm1_clear(s[2]), .i_status_read(s[3]), .i_time_wr(twr),
      .i_wr_tenths(4'h0), .i_wr_sec(sec), .i_wr_min(mn), .i_wr_hour(hr),
      .i_wr_weekday(wd), .i_wr_date(dt), .i_wr_month(mo), .i_wr_year(yr),
      .i_pd_stamp_zero(s[4]), .i_clear_stamp_ctl(s[5]),
      .i_pu_stamp_zero(s[6]), .o_tenths(), .o_sec(osec), .o_min(omin),
      .o_hour(oh), .o_pm(), .o_weekday(owd), .o_date(odt), .o_month(omo),
      .o_year(oy), .o_main_status_reg(st), .o_event_flag(ef),
      .o_event_indicator_n_o(), .o_event_indicator_n_oe(eoe),
      .o_irq_n_o(), .o_irq_n_oe(ioe), .o_freq_out(fo),
      .o_host_if_active(hact), .o_power_down_stamp(pds),
      .o_power_down_stamp_full(pdf), .o_power_up_stamp(pus));
   task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task host_op(input logic [2:0] o);
      @(posedge clk) begin go <= 1; op <= o; end
      @(posedge clk) go <= 0;
      cyc(4);
   endtask
   task wst(input integer b);
      for (k = 0; k < 2000 && st[b] !== 1'b1; k++) @(posedge clk);
   endtask
   // Stamp expected one minute on, as the seconds roll over from 59.
   function logic [26:0] stp();
      return {yr, mo, dt, hr, mn + 6'h01};
   endfunction
   task tally_and_finish;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish;
   end
   initial begin
      k = $urandom(19968);
      mn = 6'($urandom % 58); hr = 5'($urandom % 24); wd = 3'($urandom % 7);
      dt = 5'(1 + $urandom % 28); mo = 4'(1 + $urandom % 12);
      yr = 7'($urandom % 100);
      cyc(20); nrst <= 1; cyc(4);
      chk("status", 8'h01, st);
      cyc(400);
      chk("frozen sec", 0, osec);
      @(posedge clk) twr <= 1;
      @(posedge clk) twr <= 0;
      cyc(2);
      chk("min", mn, omin);
      chk("date", {yr, mo, dt, hr, wd}, {oy, omo, odt, oh, owd});
      chk("clock fail", 0, st[0]);
      al0 <= 43'({$urandom, $urandom}) & ~43'h404_4208_207f | 43'h7b;
      al1 <= 43'({$urandom, $urandom}) & ~43'h404_4208_207f | 43'h40;
      $display("test time write finished");
      wst(4);
      chk("alarm sec", 59, osec);
      chk("irq single", 1, ioe);
      host_op(1);
      chk("alarm0 clr", 0, {st[4], ioe});
      pm <= 1; acr <= 1;
      wst(5);
      chk("irq pulse", 1, ioe);
      cyc(30);
      chk("pulse end", 0, ioe);
      chk("flag kept", 1, st[5]);
      host_op(3);
      chk("auto clear", 0, st[5:4]);
      $display("test alarms finished");
      ev <= 1; cyc(10);
      chk("gated", 0, ef);
      een <= 1; cyc(6);
      chk("event", 3, {ef, eoe});
      ev <= 0; cyc(10);
      chk("event held", 1, ef);
      host_op(0);
      chk("event clr", 0, ef);
      bak <= 1; cyc(8);
      chk("host off", 0, hact);
      chk("backup bit", 1, st[7]);
      chk("pd stamp", {1'b1, stp()}, {pdf, pds});
      ev <= 1; cyc(8);
      chk("event on bat", 0, ef);
      ev <= 0; bak <= 0; cyc(8);
      chk("pu stamp", stp(), pus);
      host_op(6); host_op(5);
      chk("stamps clr", 0, {pdf, pds, pus});
      hob <= 1; eob <= 1; bak <= 1; ev <= 1; cyc(8);
      chk("host on bat", 3, {hact, ef});
      host_op(4);
      chk("pd zero", 0, pds);
      ev <= 0; bak <= 0; cyc(8);
      $display("test event and stamps finished");
      for (int i = 0; i < 8; i++) begin
         r = 3'($urandom);
         trip <= r[0]; b85 <= r[1] | r[2]; b75 <= r[2]; cyc(8);
         chk("supply", {r[0], r[1] | r[2], r[2]}, st[3:1]);
      end
      fsel <= 3'h0; cyc(8);
      chk("freq_out off", 0, fo);
      // The line clock toggles every two cycles, so 400 cycles hold 100 rises.
      fsel <= 3'h5; cyc(8); k = 0;
      for (int i = 0; i < 400; i++) begin
         r[0] = fo;
         @(posedge clk);
         if (fo === 1'b1 && r[0] === 1'b0) k++;
      end
      chk("freq_out line", 100, k);
      $display("test flags finished");
      tally_and_finish;
   end
endmodule // test_rtc_event_alarm_core
`default_nettype wire
